//--- dbm_pin_mux.sv
// Function
// - drop bus enable picks shared pin function
// - enabled, first pin drives drop bit 4
// - enabled, second pin drives drop bit 5
// - drop bits change on drop clock rise
// - disabled, first pin carries ch8 line data
// - disabled, second pin carries ch0 line clock
// - line data updates on line clock rise
// - ch8 io bit 2 selects falling edge
// - ch0 invert bit lives in ch0 io register
// - sts-1 mode always updates on rising edge
`timescale 1ns/1ps
`default_nettype none

module dbm_pin_mux
    import dbm_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic [15:0] reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [7:0]       reg_rdata,
    input  wire logic        drop_bus_clock_ch0,
    input  wire logic [7:0]  drop_word,
    input  wire logic        line_bit_ch8,
    input  wire logic        line_bit_valid,
    output logic             line_bit_ready,
    output logic             drop_bus_bit4_ch0,
    output logic             drop_bus_bit5_ch0,
    output logic             line_invert_ch0
);

    dbm_state_s   st_q;
    dbm_state_s   st_d;
    dbm_reg_req_s req;
    logic         buf_data;
    logic         buf_valid;
    logic         buf_pop;
    logic         drop_rise;
    logic         div_wrap;
    logic         line_rise;
    logic         line_fall;
    logic         inv_ch8;
    logic         upd_line;
    logic         bus_en;

    // address match used by both the write and the read decode
    function automatic logic hit(input logic [15:0] a, input logic [15:0] ref_a);
        hit = (a == ref_a);
    endfunction : hit

    // effective falling-edge select, never in sts-1 operation
    function automatic logic eff_invert(input logic [7:0] io, input logic sts1);
        eff_invert = io[DBM_BIT_CLK_INVERT] & ~sts1;
    endfunction : eff_invert

    // bundle the register port
    assign req.addr  = reg_addr;
    assign req.wdata = reg_wdata;
    assign req.wr    = reg_wr;
    assign req.rd    = reg_rd;

    // stream buffer for ch8 serial line bits
    dbm_buf #(
        .W (1),
        .D (2)
    ) u_buf (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .in_data   (line_bit_ch8),
        .in_valid  (line_bit_valid),
        .in_ready  (line_bit_ready),
        .out_data  (buf_data),
        .out_valid (buf_valid),
        .out_ready (buf_pop)
    );

    // drop clock edge from the second and third sync stages
    assign drop_rise = st_q.dclk_s2 & ~st_q.dclk_s3;

    // line clock divider events
    assign div_wrap  = (st_q.div_cnt == DBM_LINE_DIV_HALF - 4'h1);
    assign line_rise = div_wrap & ~st_q.line_clk;
    assign line_fall = div_wrap & st_q.line_clk;

    assign inv_ch8  = eff_invert(st_q.io_ch8, st_q.mux_ctrl[DBM_BIT_STS1_CH8]);
    assign upd_line = inv_ch8 ? line_fall : line_rise;
    assign buf_pop  = upd_line;
    assign bus_en   = st_q.mux_ctrl[DBM_BIT_BUS_EN];

    // next-state logic for the whole block
    always_comb begin
        st_d = st_q;

        // drop clock synchroniser and edge history
        st_d.dclk_s1 = drop_bus_clock_ch0;
        st_d.dclk_s2 = st_q.dclk_s1;
        st_d.dclk_s3 = st_q.dclk_s2;

        // drop bits only on drop clock rise
        if (drop_rise) begin
            st_d.drop_b4 = drop_word[DBM_DROP_BIT_A];
            st_d.drop_b5 = drop_word[DBM_DROP_BIT_B];
        end

        // line clock divider
        if (div_wrap) begin
            st_d.div_cnt  = '0;
            st_d.line_clk = ~st_q.line_clk;
        end else begin
            st_d.div_cnt = st_q.div_cnt + 4'h1;
        end

        // serial data shifts out on update edge
        if (upd_line) begin
            st_d.line_data = buf_valid ? buf_data : 1'b0;
        end

        // register writes
        if (req.wr) begin
            if (hit(req.addr, DBM_ADDR_MUX_CTRL)) begin
                st_d.mux_ctrl = req.wdata;
            end else if (hit(req.addr, DBM_ADDR_IO_CH0)) begin
                st_d.io_ch0 = req.wdata;
            end else if (hit(req.addr, DBM_ADDR_IO_CH8)) begin
                st_d.io_ch8 = req.wdata;
            end else if (hit(req.addr, DBM_ADDR_STATUS)) begin
                if (req.wdata[DBM_BIT_UNDERRUN]) begin
                    st_d.underrun = 1'b0;
                end
            end
        end

        // underrun sticky, set wins over clear
        if (upd_line && !buf_valid) begin
            st_d.underrun = 1'b1;
        end

        // register reads, data valid only in the next cycle
        st_d.rdata = 8'h00;
        if (req.rd) begin
            if (hit(req.addr, DBM_ADDR_MUX_CTRL)) begin
                st_d.rdata = st_q.mux_ctrl;
            end else if (hit(req.addr, DBM_ADDR_IO_CH0)) begin
                st_d.rdata = st_q.io_ch0;
            end else if (hit(req.addr, DBM_ADDR_IO_CH8)) begin
                st_d.rdata = st_q.io_ch8;
            end else if (hit(req.addr, DBM_ADDR_STATUS)) begin
                st_d.rdata[DBM_BIT_UNDERRUN]   = st_q.underrun;
                st_d.rdata[DBM_BIT_BUF_VALID]  = buf_valid;
                st_d.rdata[DBM_BIT_INV_EFF]    = inv_ch8;
                st_d.rdata[DBM_BIT_BUS_ACTIVE] = bus_en;
            end
        end

        // pin function from drop bus enable
        if (bus_en) begin
            // drop bit 4 on first pin
            st_d.pins.pin_d21 = st_q.drop_b4;
            // drop bit 5 on second pin
            st_d.pins.pin_c21 = st_q.drop_b5;
        end else begin
            // ch8 line data on first pin
            st_d.pins.pin_d21 = st_d.line_data;
            // ch0 line clock on second pin
            st_d.pins.pin_c21 = st_d.line_clk;
        end
    end

    // state register
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q          <= '0;
            st_q.io_ch0   <= DBM_RST_IO;
            st_q.io_ch8   <= DBM_RST_IO;
            st_q.mux_ctrl <= DBM_RST_MUX_CTRL;
        end else begin
            st_q <= st_d;
        end
    end

    // outputs straight from flip-flops, except ch0 invert which is gated from two register bits and line_bit_ready decoded from the buffer count
    assign reg_rdata         = st_q.rdata;
    assign drop_bus_bit4_ch0 = st_q.pins.pin_d21;
    assign drop_bus_bit5_ch0 = st_q.pins.pin_c21;
    assign line_invert_ch0   = eff_invert(st_q.io_ch0, st_q.mux_ctrl[DBM_BIT_STS1_CH0]);

    // ---- assertions ----
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_bus_on2;
        st_q.mux_ctrl[DBM_BIT_BUS_EN] [*2];
    endsequence

    sequence s_bus_off2;
        !st_q.mux_ctrl[DBM_BIT_BUS_EN] [*2];
    endsequence

    sequence s_line_rise;
        $rose(st_q.line_clk);
    endsequence

    sequence s_line_fall;
        $fell(st_q.line_clk);
    endsequence

    // pin shows captured drop bit 4 a cycle later
    a_pin_a_drop: assert property (
        s_bus_on2 |-> drop_bus_bit4_ch0 == $past(st_q.drop_b4))
        else $error("first pin does not carry drop bit 4");

    a_pin_b_drop: assert property (
        s_bus_on2 |-> drop_bus_bit5_ch0 == $past(st_q.drop_b5))
        else $error("second pin does not carry drop bit 5");

    // first pin line data when disabled
    a_pin_a_line: assert property (
        s_bus_off2 |-> drop_bus_bit4_ch0 == st_q.line_data)
        else $error("first pin does not carry ch8 line data");

    // second pin line clock when disabled
    a_pin_b_clk: assert property (
        s_bus_off2 |-> drop_bus_bit5_ch0 == st_q.line_clk)
        else $error("second pin does not carry ch0 line clock");

    // drop bit 4 moves only after a drop clock rise
    a_drop_edge_only: assert property (
        $changed(st_q.drop_b4) |-> $past(drop_rise))
        else $error("drop bit changed without drop clock rise");

    // synchronised rise captures the word bit
    a_drop_capture_bit: assert property (
        $rose(st_q.dclk_s2) ##1 1'b1 |-> st_q.drop_b5 == $past(drop_word[DBM_DROP_BIT_B]))
        else $error("drop bit 5 not captured on drop clock rise");

    a_line_rise_upd: assert property (
        ($changed(st_q.line_data) && !$past(inv_ch8)) |-> s_line_rise)
        else $error("line data changed away from rising line clock");

    a_line_fall_upd: assert property (
        ($changed(st_q.line_data) && $past(inv_ch8)) |-> s_line_fall)
        else $error("inverted line data changed away from falling edge");

    // sts-1 mode never uses the falling edge
    a_sts1_rise_only: assert property (
        (st_q.mux_ctrl[DBM_BIT_STS1_CH8] && $stable(st_q.mux_ctrl)) |-> !inv_ch8)
        else $error("falling edge active in sts-1 operation");

    // ch0 io register reads back one cycle later
    a_io_ch0_read: assert property (
        (reg_rd && reg_addr == DBM_ADDR_IO_CH0) |=> reg_rdata == $past(st_q.io_ch0))
        else $error("ch0 io register read back wrong");

    // line clock high for the full half period
    a_clk_half_high: assert property (
        s_line_rise |-> st_q.line_clk [*2] ##1 !st_q.line_clk)
        else $error("line clock high phase has wrong length");

    // invert bit only set by a write
    a_inv_write_only: assert property (
        $rose(st_q.io_ch8[DBM_BIT_CLK_INVERT]) |-> $past(reg_wr)
            && $past(reg_addr) == DBM_ADDR_IO_CH8)
        else $error("invert bit set without a register write");

    // line clock low for the full half period
    a_clk_half_low: assert property (
        s_line_fall |-> !st_q.line_clk [*2] ##1 st_q.line_clk)
        else $error("line clock low phase has wrong length");

    // first pin follows drop bit 4 once the bus takes over
    a_bus_take_a: assert property (
        $rose(bus_en) |=> drop_bus_bit4_ch0 == $past(st_q.drop_b4))
        else $error("first pin not handed to drop bus");

    // second pin follows drop bit 5 once the bus takes over
    a_bus_take_b: assert property (
        $rose(bus_en) |=> drop_bus_bit5_ch0 == $past(st_q.drop_b5))
        else $error("second pin not handed to drop bus");

    // mux control write lands next cycle
    a_mux_write: assert property (
        (reg_wr && reg_addr == DBM_ADDR_MUX_CTRL) |=> st_q.mux_ctrl == $past(reg_wdata))
        else $error("mux control write lost");

    // ch8 io control write lands next cycle
    a_io_ch8_write: assert property (
        (reg_wr && reg_addr == DBM_ADDR_IO_CH8) |=> st_q.io_ch8 == $past(reg_wdata))
        else $error("ch8 io control write lost");

    // ch0 io control write lands next cycle
    a_io_ch0_write: assert property (
        (reg_wr && reg_addr == DBM_ADDR_IO_CH0) |=> st_q.io_ch0 == $past(reg_wdata))
        else $error("ch0 io control write lost");

    // ch0 invert output off in sts-1 operation
    a_ch0_sts1_inv: assert property (
        st_q.mux_ctrl[DBM_BIT_STS1_CH0] |-> !line_invert_ch0)
        else $error("ch0 invert active in sts-1 operation");

    // empty buffer at an update edge flags underrun
    a_underrun_set: assert property (
        (upd_line && !buf_valid) |=> st_q.underrun)
        else $error("underrun not flagged on empty buffer");

    // underrun clears only by a status write
    a_underrun_clear: assert property (
        $fell(st_q.underrun) |-> $past(reg_wr) && $past(reg_addr) == DBM_ADDR_STATUS)
        else $error("underrun cleared without a status write");

    a_rdata_idle: assert property (
        !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not zero outside a read");

    a_unmapped_read: assert property (
        (reg_rd && reg_addr != DBM_ADDR_MUX_CTRL && reg_addr != DBM_ADDR_STATUS
            && reg_addr != DBM_ADDR_IO_CH0 && reg_addr != DBM_ADDR_IO_CH8)
            |=> reg_rdata == 8'h00)
        else $error("unmapped read returned data");

endmodule : dbm_pin_mux

`default_nettype wire

//--- dbm_pkg.sv
package dbm_pkg;

    // register map, 16-bit byte addresses on the plain register port
    localparam logic [15:0] DBM_ADDR_MUX_CTRL = 16'h0000;
    localparam logic [15:0] DBM_ADDR_STATUS   = 16'h0002;
    localparam logic [15:0] DBM_ADDR_IO_CH0   = 16'h1f01;
    localparam logic [15:0] DBM_ADDR_IO_CH8   = 16'h9f01;

    // reset values
    localparam logic [7:0] DBM_RST_MUX_CTRL = 8'h00;
    localparam logic [7:0] DBM_RST_IO       = 8'h00;

    // field positions
    localparam int DBM_BIT_CLK_INVERT = 2;  // io control, line clock edge invert
    localparam int DBM_BIT_BUS_EN     = 0;  // mux control, drop bus enable ch0
    localparam int DBM_BIT_STS1_CH8   = 1;  // mux control, ch8 runs sts-1
    localparam int DBM_BIT_STS1_CH0   = 2;  // mux control, ch0 runs sts-1
    localparam int DBM_BIT_UNDERRUN   = 0;  // status, sticky, write 1 to clear
    localparam int DBM_BIT_BUF_VALID  = 1;  // status, buffer holds a bit
    localparam int DBM_BIT_INV_EFF    = 2;  // status, ch8 falling edge active
    localparam int DBM_BIT_BUS_ACTIVE = 3;  // status, pins carry drop bus

    // drop bus bits routed to the shared pins
    localparam int DBM_DROP_BIT_A = 4;
    localparam int DBM_DROP_BIT_B = 5;

    // line clock divider: half period in system clocks
    localparam int          DBM_DIV_W         = 4;
    localparam logic [3:0]  DBM_LINE_DIV_HALF = 4'h2;

    // register port request
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } dbm_reg_req_s;

    // shared output pins
    typedef struct packed {
        logic pin_d21;  // drop bit 4 or ch8 line data
        logic pin_c21;  // drop bit 5 or ch0 line clock
    } dbm_pins_s;

    // whole state of the mux block
    typedef struct packed {
        logic [7:0]           mux_ctrl;
        logic [7:0]           io_ch0;
        logic [7:0]           io_ch8;
        logic [7:0]           rdata;
        logic                 dclk_s1;
        logic                 dclk_s2;
        logic                 dclk_s3;
        logic                 drop_b4;
        logic                 drop_b5;
        logic [DBM_DIV_W-1:0] div_cnt;
        logic                 line_clk;
        logic                 line_data;
        logic                 underrun;
        dbm_pins_s            pins;
    } dbm_state_s;

endpackage : dbm_pkg

//--- dbm_buf.sv
`timescale 1ns/1ps
`default_nettype none

// two-entry buffer with valid/ready on both sides
module dbm_buf
    import dbm_pkg::*;
#(
    parameter int W = 1,
    parameter int D = 2
) (
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    output logic [W-1:0]      out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);

    localparam int PW = (D > 1) ? $clog2(D) : 1;

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [PW-1:0]       wptr;
        logic [PW-1:0]       rptr;
        logic [PW:0]         count;
    } dbm_buf_s;

    dbm_buf_s st_q;
    dbm_buf_s st_d;
    logic     push;
    logic     pop;

    // honest full and empty flags
    assign in_ready  = (st_q.count != (PW+1)'(D));
    assign out_valid = (st_q.count != '0);
    assign out_data  = st_q.mem[st_q.rptr];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // pointer and count update
    always_comb begin
        st_d = st_q;
        if (push) begin
            st_d.mem[st_q.wptr] = in_data;
            st_d.wptr = (st_q.wptr == PW'(D-1)) ? '0 : st_q.wptr + 1'b1;
        end
        if (pop) begin
            st_d.rptr = (st_q.rptr == PW'(D-1)) ? '0 : st_q.rptr + 1'b1;
        end
        st_d.count = st_q.count + (PW+1)'(push) - (PW+1)'(pop);
    end

    // state register
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

endmodule : dbm_buf

`default_nettype wire

//--- dbm_liu_model.sv
`timescale 1ns/1ps
`default_nettype none

// line interface unit: takes a bit half a period after each update edge
module dbm_liu_model (
    input  wire logic  clk,
    input  wire logic  line_clock,
    input  wire logic  line_data,
    input  wire logic  upd_on_fall,
    input  wire logic  arm,
    output logic [7:0] word,
    output logic       got,
    output logic [7:0] bad_edges
);
    logic       clk_q;
    logic       data_q;
    logic       armed;
    logic [3:0] cnt;
    logic       edge_seen;

    assign edge_seen = line_clock !== clk_q;

    // pins seen in the system clock domain, so no race with the mux outputs
    always_ff @(posedge clk) begin
        clk_q <= line_clock;
        data_q <= line_data;
        if (arm) begin
            armed <= 1'b0;
            cnt <= 4'h0;
            got <= 1'b0;
            bad_edges <= 8'h00;
        end else begin
            // data moves only on update edge
            if (line_data !== data_q && !(edge_seen && line_clock === ~upd_on_fall)) begin
                bad_edges <= bad_edges + 8'h01;
            end
            if (edge_seen && line_clock === upd_on_fall && !got && (armed || line_data)) begin
                armed <= 1'b1;
                word <= {word[6:0], line_data};
                cnt <= cnt + 4'h1;
                got <= (cnt == 4'h7);
            end
        end
    end
endmodule : dbm_liu_model

`default_nettype wire

//--- dbm_pin_mux_bench.sv
`timescale 1ns/1ps
`default_nettype none

module dbm_pin_mux_bench;
    import dbm_pkg::*;

    typedef struct packed {
        logic [15:0] a;
        logic [7:0]  w;
        logic [7:0]  r;
        logic        v;
    } dbm_row_s;

    localparam logic [7:0] PAT = 8'hb4;

    logic        clk;
    logic        sys_rst;
    logic        reg_wr;
    logic        reg_rd;
    logic [15:0] reg_addr;
    logic [7:0]  reg_wdata;
    logic [7:0]  reg_rdata;
    logic [7:0]  rd;
    logic        drop_clk;
    logic [7:0]  drop_word;
    logic        line_bit_ch8;
    logic        line_bit_valid;
    logic        line_bit_ready;
    logic        pin_a;
    logic        pin_b;
    logic        inv;
    logic        arm;
    logic        upd;
    logic [7:0]  word;
    logic [7:0]  bad;
    logic        got;
    int          mismatches = 0;
    int          checked = 0;
    int          cycles = 0;
    int          stalls;
    int          n;

    // register rows: address, write, read back, expected ch0 invert
    dbm_row_s rows [6] = '{
        '{DBM_ADDR_IO_CH0, 8'h04, 8'h04, 1'b1},
        '{DBM_ADDR_MUX_CTRL, 8'h04, 8'h04, 1'b0},
        '{DBM_ADDR_MUX_CTRL, 8'h00, 8'h00, 1'b1},
        '{DBM_ADDR_IO_CH8, 8'hfb, 8'hfb, 1'b1},
        '{16'h0004, 8'hff, 8'h00, 1'b1},
        '{DBM_ADDR_IO_CH0, 8'ha3, 8'ha3, 1'b0}};
    // line modes: io ch8 value, mux value
    logic [15:0] modes [3] = '{16'h0000, 16'h0400, 16'h0402};

    dbm_pin_mux i_dut (
        .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .drop_bus_clock_ch0(drop_clk), .drop_word(drop_word), .line_bit_ch8(line_bit_ch8),
        .line_bit_valid(line_bit_valid), .line_bit_ready(line_bit_ready),
        .drop_bus_bit4_ch0(pin_a), .drop_bus_bit5_ch0(pin_b), .line_invert_ch0(inv));

    dbm_liu_model i_liu (
        .clk(clk), .line_clock(pin_b), .line_data(pin_a), .upd_on_fall(upd),
        .arm(arm), .word(word), .got(got), .bad_edges(bad));

    // system clock and an unrelated drop bus clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        drop_clk = 1'b0;
        #37;
        forever #160 drop_clk = ~drop_clk;
    end

    task automatic close_out;
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : close_out

    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            close_out();
        end
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic reg_write(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [15:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 rd = reg_rdata;
    endtask : reg_read

    // hold the bit until ready is seen at an edge
    task automatic push(input logic b);
        line_bit_ch8 <= b;
        line_bit_valid <= 1'b1;
        do begin
            @(posedge clk);
            if (line_bit_ready !== 1'b1) stalls++;
        end while (line_bit_ready !== 1'b1);
    endtask : push

    initial begin
        sys_rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 16'h0000;
        reg_wdata = 8'h00;
        drop_word = 8'h00;
        line_bit_ch8 = 1'b0;
        line_bit_valid = 1'b0;
        arm = 1'b1;
        upd = 1'b0;
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        reg_read(DBM_ADDR_IO_CH0);
        check("io ch0 reset", rd, 8'h00);
        reg_read(DBM_ADDR_IO_CH8);
        check("io ch8 reset", rd, 8'h00);
        check("invert reset", {7'h00, inv}, 8'h00);
        foreach (rows[i]) begin
            reg_write(rows[i].a, rows[i].w);
            reg_read(rows[i].a);
            check("readback", rd, rows[i].r);
            check("ch0 invert", {7'h00, inv}, {7'h00, rows[i].v});
        end
        // drop bus owns the pins
        reg_write(DBM_ADDR_MUX_CTRL, 8'h01);
        drop_word <= 8'h10;
        @(posedge drop_clk);
        repeat (6) @(posedge clk);
        #1 check("drop pins", {6'h00, pin_a, pin_b}, 8'h02);
        drop_word <= 8'h20;
        @(posedge clk);
        #1 check("drop hold", {6'h00, pin_a, pin_b}, 8'h02);
        @(posedge drop_clk);
        repeat (5) @(posedge clk);
        #1 check("drop next", {6'h00, pin_a, pin_b}, 8'h01);
        reg_read(DBM_ADDR_STATUS);
        check("bus active", rd & 8'h08, 8'h08);
        // line interface owns the pins, one pass per edge mode
        foreach (modes[m]) begin
            reg_write(DBM_ADDR_IO_CH8, modes[m][15:8]);
            reg_write(DBM_ADDR_MUX_CTRL, modes[m][7:0]);
            upd <= modes[m][10] & ~modes[m][1];
            repeat (8) @(posedge clk);
            arm <= 1'b0;
            stalls = 0;
            for (n = 0; n < 8; n++) push(PAT[7-n]);
            line_bit_valid <= 1'b0;
            for (n = 0; n < 400 && got !== 1'b1; n++) @(posedge clk);
            check("line word", word, PAT);
            check("update edge", bad, 8'h00);
            check("buffer full", {7'h00, stalls != 0}, 8'h01);
            reg_read(DBM_ADDR_STATUS);
            check("edge status", rd & 8'h07, {5'h00, upd, 2'b01});
            arm <= 1'b1;
        end
        close_out();
    end
endmodule : dbm_pin_mux_bench

`default_nettype wire
